// File: verilog/asp_pkg.sv
// Constants and state codes for the asynchronous serial port.
// Assumes a 100 MHz ref_clk and an APB master on the register side.
package asp_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_FMT     = 8'h04;
  localparam logic [7:0] ADR_BAUD_LO = 8'h08;
  localparam logic [7:0] ADR_BAUD_HI = 8'h0c;
  localparam logic [7:0] ADR_TXDATA  = 8'h10;
  localparam logic [7:0] ADR_RXDATA  = 8'h14;
  localparam logic [7:0] ADR_RXEMU   = 8'h18;
  localparam logic [7:0] ADR_STATUS  = 8'h1c;
  localparam logic [7:0] ADR_MISC    = 8'h20;
  // Values after reset
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  FMT_RST  = 8'h07;
  localparam logic [7:0]  MISC_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0363;
  // FIFO geometry
  localparam logic [4:0] FIFO_FULL = 5'h10;
  // Idle bit times that mark an address frame, and wake gap
  localparam logic [3:0] IDLE_BITS = 4'ha;
  // Control fields
  localparam int C_TX_EN  = 0;
  localparam int C_RX_EN  = 1;
  localparam int C_TX_IE  = 2;
  localparam int C_RX_IE  = 3;
  localparam int C_BRK_IE = 4;
  // Frame format fields; bits 2:0 hold data length minus one
  localparam int F_PAR_EN = 3;
  localparam int F_ODD    = 4;
  localparam int F_STOP2  = 5;
  localparam int F_ADRBIT = 6;
  localparam int F_IDLE   = 7;
  // Miscellaneous fields
  localparam int M_AB_GO   = 0;
  localparam int M_TX_ADR  = 1;
  localparam int M_SLEEP   = 2;
  localparam int M_TX_WAKE = 3;
  localparam int M_AB_BUSY = 4;
  // Status fields
  localparam int S_TX_RDY = 0;
  localparam int S_TX_EMP = 1;
  localparam int S_RX_RDY = 2;
  localparam int S_BRK    = 3;
  localparam int S_RX_ERR = 4;
  localparam int S_PE     = 5;
  localparam int S_OE     = 6;
  localparam int S_FE     = 7;
  // Serial engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_START = 7'h02,
    ST_DATA  = 7'h04,
    ST_ADDR  = 7'h08,
    ST_PAR   = 7'h10,
    ST_STOP  = 7'h20,
    ST_GAP   = 7'h40
  } asp_st_t;
endpackage

// File: verilog/asp_uart.sv
// Asynchronous serial port: APB registers, 16-deep FIFOs, NRZ link.
// Assumes serial_rx_pin is asynchronous; all else is on ref_clk.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// RULE_01: NRZ data on one transmit output and one receive input.
// RULE_02: Sixteen-entry FIFO per direction, separate enables and interrupt enables.
// RULE_03: Transmitter and receiver run independently or together.
// RULE_04: Bit period set by a 16-bit baud value.
// RULE_05: One start bit, then one to eight data bits.
// RULE_06: Optional parity bit, even or odd.
// RULE_07: One or two stop bits.
// RULE_08: Receiver flags parity, overrun, framing and break separately.
// RULE_09: Idle-line and address-bit multiprocessor wake-up modes.
// RULE_10: Transmit ready flag set while the transmit buffer has room.
// RULE_11: Transmitter empty flag set while the shift register is idle.
// RULE_12: Receive ready flag shows data waiting in the receive buffer.
// RULE_13: Break flag set on a break on the receive line.
// RULE_14: Summary error flag set when any receive error exists.
// RULE_15: Own interrupt enables for transmit and receive; break has its own.
// RULE_16: Transmit shift register sends buffer characters bit by bit.
// RULE_17: Received character goes to data buffer and emulation buffer.
// RULE_18: Hardware measures incoming baud rate automatically.
// RULE_19: Registers are eight bits in the low byte.
// RULE_20: Upper bits read zero and ignore writes.
// RULE_21: Start low, stop high, idle high, least significant bit first.
module asp_uart (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             tx_irq,
  output logic             rx_irq
);
  typedef struct packed {
    logic [15:0][7:0] tx_fifo;
    logic [15:0][7:0] rx_fifo;
    logic [3:0]       tx_wp;
    logic [3:0]       tx_rp;
    logic [4:0]       tx_cnt;
    logic [3:0]       rx_wp;
    logic [3:0]       rx_rp;
    logic [4:0]       rx_cnt;
    logic [7:0]       ctrl;
    logic [7:0]       fmt;
    logic [7:0]       misc;
    logic [7:0]       rx_emu;
    logic [15:0]      baud;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             rx_s1;
    logic             rx_s2;
    asp_pkg::asp_st_t tx_st;
    asp_pkg::asp_st_t rx_st;
    logic [7:0]       tx_sh;
    logic [7:0]       rx_sh;
    logic [3:0]       tx_bits;
    logic [3:0]       rx_bits;
    logic [15:0]      tx_bcnt;
    logic [15:0]      rx_bcnt;
    logic             tx_par;
    logic             tx_abit;
    logic             txd;
    logic             rx_par;
    logic             rx_abit;
    logic             rx_brkz;
    logic             rx_perr;
    logic [3:0]       idle_cnt;
    logic             pe;
    logic             oe;
    logic             fe;
    logic             brk;
    logic             ab_busy;
    logic             ab_meas;
    logic [15:0]      ab_cnt;
    logic             tx_irq;
    logic             rx_irq;
  } asp_state_t;

  asp_state_t s;
  asp_state_t next_s;
  logic       tx_tick;
  logic       rx_tick;
  logic       rxd;
  logic       rx_take;
  logic [7:0] stat;
  logic       xfer;

  // Serial engine helpers
  assign tx_tick = (s.tx_bcnt == 16'h0000);
  assign rx_tick = (s.rx_bcnt == 16'h0000);
  assign rxd     = s.rx_s2;
  assign xfer    = psel && penable && s.pready;
  // Sleeping receiver in a wake-up mode keeps only address frames
  assign rx_take = !(s.fmt[asp_pkg::F_ADRBIT] || s.fmt[asp_pkg::F_IDLE])
                   || !s.misc[asp_pkg::M_SLEEP] || s.rx_abit;

  // RULE_10 RULE_11 RULE_12 RULE_14 status flags; summary ORs all four
  always_comb begin
    stat = 8'h00;
    stat[asp_pkg::S_TX_RDY] = (s.tx_cnt != asp_pkg::FIFO_FULL);
    stat[asp_pkg::S_TX_EMP] = (s.tx_st == asp_pkg::ST_IDLE);
    stat[asp_pkg::S_RX_RDY] = (s.rx_cnt != 5'h00);
    stat[asp_pkg::S_BRK]    = s.brk;
    stat[asp_pkg::S_RX_ERR] = s.pe | s.oe | s.fe | s.brk;
    stat[asp_pkg::S_PE]     = s.pe;
    stat[asp_pkg::S_OE]     = s.oe;
    stat[asp_pkg::S_FE]     = s.fe;
  end

  // Next-state logic: bus first so engine sets win over clears
  always_comb begin
    next_s = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.rx_s1   = serial_rx_pin;
    next_s.rx_s2   = s.rx_s1;
    next_s.misc[asp_pkg::M_AB_GO] = 1'b0;
    // Setup phase: answer registered for the first access cycle
    if (psel && !penable && !s.pready) begin
      next_s.pready = 1'b1;
      // RULE_20 upper bits zero
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        asp_pkg::ADR_CTRL:    next_s.prdata[7:0] = s.ctrl;
        asp_pkg::ADR_FMT:     next_s.prdata[7:0] = s.fmt;
        asp_pkg::ADR_BAUD_LO: next_s.prdata[7:0] = s.baud[7:0];
        asp_pkg::ADR_BAUD_HI: next_s.prdata[7:0] = s.baud[15:8];
        asp_pkg::ADR_TXDATA:  next_s.prdata[7:0] = 8'h00;
        asp_pkg::ADR_RXDATA:  next_s.prdata[7:0] = s.rx_fifo[s.rx_rp];
        asp_pkg::ADR_RXEMU:   next_s.prdata[7:0] = s.rx_emu;
        asp_pkg::ADR_STATUS:  next_s.prdata[7:0] = stat;
        asp_pkg::ADR_MISC: begin
          next_s.prdata[7:0] = s.misc;
          next_s.prdata[asp_pkg::M_AB_BUSY] = s.ab_busy;
        end
        default:              next_s.pslverr = 1'b1;
      endcase
    end
    // RULE_19 low byte only
    if (xfer && pwrite) begin
      unique case (paddr)
        asp_pkg::ADR_CTRL:    next_s.ctrl = pwdata[7:0];
        asp_pkg::ADR_FMT:     next_s.fmt = pwdata[7:0];
        asp_pkg::ADR_BAUD_LO: next_s.baud[7:0] = pwdata[7:0];
        asp_pkg::ADR_BAUD_HI: next_s.baud[15:8] = pwdata[7:0];
        asp_pkg::ADR_TXDATA: begin
          if (s.tx_cnt != asp_pkg::FIFO_FULL) begin
            next_s.tx_fifo[s.tx_wp] = pwdata[7:0];
            next_s.tx_wp = s.tx_wp + 4'h1;
            next_s.tx_cnt = next_s.tx_cnt + 5'h01;
          end
        end
        asp_pkg::ADR_STATUS: begin
          // Write one to clear
          if (pwdata[asp_pkg::S_PE]) next_s.pe = 1'b0;
          if (pwdata[asp_pkg::S_OE]) next_s.oe = 1'b0;
          if (pwdata[asp_pkg::S_FE]) next_s.fe = 1'b0;
          if (pwdata[asp_pkg::S_BRK]) next_s.brk = 1'b0;
        end
        asp_pkg::ADR_MISC: begin
          next_s.misc = {4'h0, pwdata[3:0]};
          // RULE_18 arm rate measurement
          if (pwdata[asp_pkg::M_AB_GO]) begin
            next_s.ab_busy = 1'b1;
            next_s.ab_meas = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // RULE_02 pop on read; emulation copy stays
    if (xfer && !pwrite && paddr == asp_pkg::ADR_RXDATA && s.rx_cnt != 5'h00) begin
      next_s.rx_rp = s.rx_rp + 4'h1;
      next_s.rx_cnt = next_s.rx_cnt - 5'h01;
    end

    // RULE_04 bit period is baud plus one cycles
    next_s.tx_bcnt = tx_tick ? s.baud : s.tx_bcnt - 16'h0001;
    // RULE_03 transmitter runs on its own state
    unique case (s.tx_st)
      asp_pkg::ST_IDLE: begin
        next_s.tx_bcnt = s.baud;
        // RULE_16 load shift register from buffer
        if (s.ctrl[asp_pkg::C_TX_EN] && s.tx_cnt != 5'h00) begin
          next_s.tx_sh = s.tx_fifo[s.tx_rp];
          next_s.tx_rp = s.tx_rp + 4'h1;
          next_s.tx_cnt = next_s.tx_cnt - 5'h01;
          next_s.tx_par = s.fmt[asp_pkg::F_ODD];
          next_s.tx_abit = s.misc[asp_pkg::M_TX_ADR];
          // RULE_09 idle gap marks the next frame as address
          if (s.fmt[asp_pkg::F_IDLE] && s.misc[asp_pkg::M_TX_WAKE]) begin
            next_s.misc[asp_pkg::M_TX_WAKE] = 1'b0;
            next_s.tx_bits = asp_pkg::IDLE_BITS;
            next_s.tx_st = asp_pkg::ST_GAP;
          end else begin
            next_s.tx_st = asp_pkg::ST_START;
          end
        end
      end
      asp_pkg::ST_GAP: begin
        if (tx_tick) begin
          if (s.tx_bits == 4'h0) next_s.tx_st = asp_pkg::ST_START;
          else next_s.tx_bits = s.tx_bits - 4'h1;
        end
      end
      asp_pkg::ST_START: begin
        // RULE_05 data length from format field
        if (tx_tick) begin
          next_s.tx_bits = {1'b0, s.fmt[2:0]};
          next_s.tx_st = asp_pkg::ST_DATA;
        end
      end
      asp_pkg::ST_DATA: begin
        if (tx_tick) begin
          next_s.tx_par = s.tx_par ^ s.tx_sh[0];
          next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
          if (s.tx_bits != 4'h0) next_s.tx_bits = s.tx_bits - 4'h1;
          else if (s.fmt[asp_pkg::F_ADRBIT]) next_s.tx_st = asp_pkg::ST_ADDR;
          else if (s.fmt[asp_pkg::F_PAR_EN]) next_s.tx_st = asp_pkg::ST_PAR;
          else begin
            next_s.tx_bits = {3'h0, s.fmt[asp_pkg::F_STOP2]};
            next_s.tx_st = asp_pkg::ST_STOP;
          end
        end
      end
      asp_pkg::ST_ADDR: begin
        if (tx_tick) begin
          next_s.tx_par = s.tx_par ^ s.tx_abit;
          next_s.tx_bits = {3'h0, s.fmt[asp_pkg::F_STOP2]};
          next_s.tx_st = s.fmt[asp_pkg::F_PAR_EN] ? asp_pkg::ST_PAR : asp_pkg::ST_STOP;
        end
      end
      asp_pkg::ST_PAR: begin
        // RULE_06 parity bit after data
        if (tx_tick) begin
          next_s.tx_bits = {3'h0, s.fmt[asp_pkg::F_STOP2]};
          next_s.tx_st = asp_pkg::ST_STOP;
        end
      end
      asp_pkg::ST_STOP: begin
        // RULE_07 one or two stop bits
        if (tx_tick) begin
          if (s.tx_bits == 4'h0) next_s.tx_st = asp_pkg::ST_IDLE;
          else next_s.tx_bits = s.tx_bits - 4'h1;
        end
      end
      default: next_s.tx_st = asp_pkg::ST_IDLE;
    endcase
    // RULE_21 line level follows the coming state, LSB first
    unique case (next_s.tx_st)
      asp_pkg::ST_START: next_s.txd = 1'b0;
      asp_pkg::ST_DATA:  next_s.txd = next_s.tx_sh[0];
      asp_pkg::ST_ADDR:  next_s.txd = next_s.tx_abit;
      asp_pkg::ST_PAR:   next_s.txd = next_s.tx_par;
      default:           next_s.txd = 1'b1;
    endcase

    // Receiver: start detected on the synchronised level only
    next_s.rx_bcnt = rx_tick ? s.baud : s.rx_bcnt - 16'h0001;
    unique case (s.rx_st)
      asp_pkg::ST_IDLE: begin
        if (!s.ctrl[asp_pkg::C_RX_EN]) begin
          next_s.rx_bcnt = s.baud;
        end else if (!rxd) begin
          // Half a bit to land mid-bit
          next_s.rx_bcnt = {1'b0, s.baud[15:1]};
          next_s.rx_abit = s.fmt[asp_pkg::F_IDLE] && (s.idle_cnt == asp_pkg::IDLE_BITS);
          next_s.idle_cnt = 4'h0;
          next_s.rx_st = asp_pkg::ST_START;
        end else if (rx_tick && s.idle_cnt != asp_pkg::IDLE_BITS) begin
          next_s.idle_cnt = s.idle_cnt + 4'h1;
        end
      end
      asp_pkg::ST_START: begin
        if (rx_tick) begin
          next_s.rx_par = s.fmt[asp_pkg::F_ODD];
          next_s.rx_brkz = 1'b1;
          next_s.rx_bits = {1'b0, s.fmt[2:0]};
          next_s.rx_st = rxd ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA;
        end
      end
      asp_pkg::ST_DATA: begin
        // RULE_17 shift in from the pin
        if (rx_tick) begin
          next_s.rx_sh = {rxd, s.rx_sh[7:1]};
          next_s.rx_par = s.rx_par ^ rxd;
          next_s.rx_brkz = s.rx_brkz & ~rxd;
          if (s.rx_bits != 4'h0) next_s.rx_bits = s.rx_bits - 4'h1;
          else if (s.fmt[asp_pkg::F_ADRBIT]) next_s.rx_st = asp_pkg::ST_ADDR;
          else if (s.fmt[asp_pkg::F_PAR_EN]) next_s.rx_st = asp_pkg::ST_PAR;
          else next_s.rx_st = asp_pkg::ST_STOP;
          next_s.rx_perr = 1'b0;
        end
      end
      asp_pkg::ST_ADDR: begin
        // RULE_09 address bit tags the frame
        if (rx_tick) begin
          next_s.rx_abit = rxd;
          next_s.rx_par = s.rx_par ^ rxd;
          next_s.rx_brkz = s.rx_brkz & ~rxd;
          next_s.rx_st = s.fmt[asp_pkg::F_PAR_EN] ? asp_pkg::ST_PAR : asp_pkg::ST_STOP;
        end
      end
      asp_pkg::ST_PAR: begin
        if (rx_tick) begin
          next_s.rx_perr = s.rx_par ^ rxd;
          next_s.rx_brkz = s.rx_brkz & ~rxd;
          next_s.rx_st = asp_pkg::ST_STOP;
        end
      end
      asp_pkg::ST_STOP: begin
        // RULE_08 errors checked on the first stop bit
        if (rx_tick) begin
          next_s.rx_st = asp_pkg::ST_IDLE;
          if (!rxd) next_s.fe = 1'b1;
          // RULE_13 whole frame low is a break
          if (!rxd && s.rx_brkz) next_s.brk = 1'b1;
          if (rx_take) begin
            if (s.rx_perr) next_s.pe = 1'b1;
            // RULE_17 copy to buffer and emulation copy
            next_s.rx_emu = s.rx_sh >> (3'h7 - s.fmt[2:0]);
            if (s.rx_cnt == asp_pkg::FIFO_FULL) begin
              next_s.oe = 1'b1;
            end else begin
              next_s.rx_fifo[s.rx_wp] = s.rx_sh >> (3'h7 - s.fmt[2:0]);
              next_s.rx_wp = s.rx_wp + 4'h1;
              next_s.rx_cnt = next_s.rx_cnt + 5'h01;
            end
          end
        end
      end
      default: next_s.rx_st = asp_pkg::ST_IDLE;
    endcase

    // RULE_18 low time of start bit sets the bit period
    if (s.ab_busy) begin
      if (!s.ab_meas) begin
        next_s.ab_cnt = 16'h0001;
        next_s.ab_meas = !rxd;
      end else if (!rxd) begin
        if (s.ab_cnt != 16'hffff) next_s.ab_cnt = s.ab_cnt + 16'h0001;
      end else begin
        next_s.baud = s.ab_cnt - 16'h0001;
        next_s.ab_busy = 1'b0;
        next_s.ab_meas = 1'b0;
      end
    end

    // RULE_15 separate enables, break has its own
    next_s.tx_irq = next_s.ctrl[asp_pkg::C_TX_IE] && next_s.tx_cnt != asp_pkg::FIFO_FULL;
    next_s.rx_irq = (next_s.ctrl[asp_pkg::C_RX_IE]
                     && (next_s.rx_cnt != 5'h00 || next_s.pe || next_s.oe || next_s.fe))
                    || (next_s.ctrl[asp_pkg::C_BRK_IE] && next_s.brk);
  end

  // State register; clock enable freezes everything
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.ctrl <= asp_pkg::CTRL_RST;
      s.fmt <= asp_pkg::FMT_RST;
      s.misc <= asp_pkg::MISC_RST;
      s.baud <= asp_pkg::BAUD_RST;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
      s.txd <= 1'b1;
      s.tx_st <= asp_pkg::ST_IDLE;
      s.rx_st <= asp_pkg::ST_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // RULE_01 outputs straight from flops
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign serial_tx_pin = s.txd;
  assign tx_irq        = s.tx_irq;
  assign rx_irq        = s.rx_irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_hi_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero"); // RULE_20

  property p_answer;
    ce && psel && !penable && !pready |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup"); // RULE_19

  property p_idle_high;
    s.tx_st == asp_pkg::ST_IDLE && ce |=> $past(next_s.tx_st) != asp_pkg::ST_IDLE || serial_tx_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high"); // RULE_21

  property p_start_low;
    s.tx_st == asp_pkg::ST_START |-> !serial_tx_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // RULE_01

  property p_tx_load;
    ce && s.tx_st == asp_pkg::ST_IDLE && s.tx_cnt != 5'h00 && s.ctrl[asp_pkg::C_TX_EN]
      |=> s.tx_st != asp_pkg::ST_IDLE && s.tx_cnt == $past(s.tx_cnt) - 5'h01 + {4'h0, $past(xfer && pwrite
      && paddr == asp_pkg::ADR_TXDATA && s.tx_cnt != asp_pkg::FIFO_FULL)};
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("buffer not loaded into shifter"); // RULE_16

  property p_bounds;
    s.tx_cnt <= asp_pkg::FIFO_FULL && s.rx_cnt <= asp_pkg::FIFO_FULL;
  endproperty
  a_bounds: assert property (p_bounds) else $error("fifo count out of range"); // RULE_02

  property p_overrun;
    ce && s.rx_st == asp_pkg::ST_STOP && rx_tick && rx_take && s.rx_cnt == asp_pkg::FIFO_FULL
      |=> s.oe;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RULE_08

  property p_err_irq;
    ce && s.ctrl[asp_pkg::C_RX_IE] && (s.pe || s.oe || s.fe)
      |=> rx_irq || !(s.ctrl[asp_pkg::C_RX_IE] && (s.pe || s.oe || s.fe));
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error not signalled"); // RULE_14

  property p_brk_irq;
    ce && s.ctrl[asp_pkg::C_BRK_IE] && s.brk ##1 s.brk && $stable(s.ctrl) |-> rx_irq;
  endproperty
  a_brk_irq: assert property (p_brk_irq) else $error("break interrupt missing"); // RULE_15

  c_tx_frame: cover property (s.tx_st == asp_pkg::ST_STOP ##1 s.tx_st == asp_pkg::ST_IDLE);
  c_rx_store: cover property (s.rx_st == asp_pkg::ST_STOP && rx_tick && ce ##1 s.rx_cnt != 5'h00);
  c_autobaud: cover property (s.ab_busy ##1 !s.ab_busy);
endmodule

// File: testbench/asp_remote.sv
// Remote serial device model facing the port's link pins.
// Assumes both ends run at BIT ref_clk cycles per bit, no parity.
`timescale 1ns/1ps
module asp_remote #(
  parameter int BIT = 8
) (
  input  wire logic       ref_clk,
  input  wire logic       tx_line,
  input  wire logic [3:0] len,
  output logic            rx_line
);
  logic [7:0] got_q[$];
  logic [7:0] shf;

  initial rx_line = 1'b1;

  // start bit, then len data bits
  always begin
    @(negedge tx_line);
    repeat (BIT / 2) @(posedge ref_clk);
    shf = 8'h00;
    for (int i = 0; i < len; i++) begin
      repeat (BIT) @(posedge ref_clk);
      shf[i] = tx_line;
    end
    // bad stop bit stored as unknown
    repeat (BIT) @(posedge ref_clk);
    got_q.push_back(tx_line ? shf : 8'hxx);
  end

  // low start, high stop; a break holds stop low
  task automatic send(input logic [7:0] d, input bit brk);
    for (int k = 0; k <= len + 2; k++) begin
      @(posedge ref_clk);
      rx_line <= (k == 0) ? 1'b0 : (k <= len) ? d[k-1] : (k == len + 1) ? ~brk : 1'b1;
      repeat (BIT - 1) @(posedge ref_clk);
    end
  endtask
endmodule

// File: testbench/async_serial_port_test.sv
// Self-checking bench for the serial port: APB tasks plus a remote model.
// Assumes the slave answers with pready; the link runs at 8 cycles a bit.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module async_serial_port_test;
  logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        rx_pin, tx_pin, tx_irq, rx_irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  len;
  int          fails, check_count;
  logic [7:0]  rst_a[6] = '{asp_pkg::ADR_CTRL, asp_pkg::ADR_FMT, asp_pkg::ADR_BAUD_LO,
                            asp_pkg::ADR_BAUD_HI, asp_pkg::ADR_MISC, asp_pkg::ADR_STATUS};
  logic [7:0]  rst_v[6] = '{asp_pkg::CTRL_RST, asp_pkg::FMT_RST, asp_pkg::BAUD_RST[7:0],
                            asp_pkg::BAUD_RST[15:8], asp_pkg::MISC_RST, 8'h03};

  asp_uart dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
  asp_remote #(.BIT(8)) remote_u (.ref_clk(ref_clk), .tx_line(tx_pin), .len(len), .rx_line(rx_pin));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) fails++;
  endtask

  // Bounded wait for characters at the remote end
  task automatic wait_rx(input int cnt);
    for (int n = 0; n < 5000 && remote_u.got_q.size() < cnt; n++) @(posedge ref_clk);
    if (remote_u.got_q.size() < cnt) fails++;
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    len = 4'h8;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values from the package, and 8'h03 for status
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rst_a[i], 32'h0);
      `CHK("reset value", {24'h0, rst_v[i]}, r)
    end
    apb(1'b1, asp_pkg::ADR_CTRL, 32'hffff_ff1c);
    apb(1'b0, asp_pkg::ADR_CTRL, 32'h0);
    `CHK("ctrl upper byte", 32'h0000_001c, r)
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, r)
    apb(1'b1, asp_pkg::ADR_BAUD_LO, 32'h07);
    apb(1'b1, asp_pkg::ADR_BAUD_HI, 32'h00);
    // Fill with transmitter off; the seventeenth write is lost
    for (int i = 0; i < 17; i++) apb(1'b1, asp_pkg::ADR_TXDATA, 32'h30 + i);
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("status full", 32'h02, r)
    `CHK("tx irq full", 1'b0, tx_irq)
    apb(1'b1, asp_pkg::ADR_CTRL, 32'h1f);
    wait_rx(16);
    for (int i = 0; i < 16; i++) `CHK("tx char", 8'(8'h30 + i), remote_u.got_q[i])
    repeat (300) @(posedge ref_clk);
    `CHK("tx count", 16, remote_u.got_q.size())
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("status drained", 32'h03, r)
    `CHK("tx irq room", 1'b1, tx_irq)
    // Four-bit characters both ways
    remote_u.got_q.delete();
    len = 4'h4;
    apb(1'b1, asp_pkg::ADR_FMT, 32'h03);
    apb(1'b1, asp_pkg::ADR_TXDATA, 32'h0b);
    wait_rx(1);
    `CHK("short tx", 8'h0b, remote_u.got_q[0])
    remote_u.send(8'h05, 1'b0);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, asp_pkg::ADR_RXDATA, 32'h0);
    `CHK("short rx", 32'h05, r)
    // Full duplex: both directions at once
    remote_u.got_q.delete();
    len = 4'h8;
    apb(1'b1, asp_pkg::ADR_FMT, 32'h07);
    fork
      remote_u.send(8'h3c, 1'b0);
      apb(1'b1, asp_pkg::ADR_TXDATA, 32'h77);
    join
    wait_rx(1);
    `CHK("duplex tx", 8'h77, remote_u.got_q[0])
    repeat (40) @(posedge ref_clk);
    `CHK("rx irq", 1'b1, rx_irq)
    apb(1'b0, asp_pkg::ADR_RXEMU, 32'h0);
    `CHK("emulation buffer", 32'h3c, r)
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("rx ready", 32'h04, r & 32'h04)
    apb(1'b0, asp_pkg::ADR_RXDATA, 32'h0);
    `CHK("rx data", 32'h3c, r)
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("rx empty", 32'h00, r & 32'h04)
    // Break sets break, summary and framing flags
    remote_u.send(8'h00, 1'b1);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("break flags", 32'h98, r & 32'h98)
    apb(1'b1, asp_pkg::ADR_STATUS, 32'h88);
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("flags cleared", 32'h00, r & 32'h98)
    // Seventeen unread characters overrun the receive FIFO
    for (int i = 0; i < 17; i++) remote_u.send(8'(i), 1'b0);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("overrun", 32'h50, r & 32'h50)
    // Even parity: the remote's stop bit lands in the parity slot
    apb(1'b1, asp_pkg::ADR_FMT, 32'h0f);
    apb(1'b1, asp_pkg::ADR_STATUS, 32'he8);
    remote_u.send(8'h01, 1'b0);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("parity good", 32'h00, r & 32'h20)
    remote_u.send(8'h03, 1'b0);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    `CHK("parity error", 32'h20, r & 32'h20)
    // Autobaud: an 8-cycle start bit gives a period value of 7
    apb(1'b1, asp_pkg::ADR_BAUD_LO, 32'h20);
    apb(1'b1, asp_pkg::ADR_MISC, 32'h01);
    remote_u.send(8'h41, 1'b0);
    apb(1'b0, asp_pkg::ADR_BAUD_LO, 32'h0);
    `CHK("autobaud period", 32'h07, r)
    apb(1'b0, asp_pkg::ADR_MISC, 32'h0);
    `CHK("autobaud idle", 32'h00, r)
    complete_run();
  end
endmodule
